// ==== common/setup_loader_pkg.sv ====
// constants and types for the serial setup chain loader
// Function
// - completion output goes low when serial or default setup has finished.
// - once finished, completion output follows the chain enable input.
// - queue read and write operations are allowed only after completion goes low.
// - serial bit captured on each serial clock rising edge while enable is low.
// - data fills the first device; later devices load after earlier ones finish.
// - a loaded device passes its serial input on to its serial output.
// - setup is held in a shift register filled from the serial stream.
// - serial or default setup chosen at master reset; shifting only on enabled edges.
package setup_loader_pkg;

  localparam int unsigned SETUP_BITS = 64;
  localparam int unsigned COUNT_W    = 7;

  localparam logic [COUNT_W-1:0]    COUNT_LAST    = 7'h3F;
  localparam logic [COUNT_W-1:0]    COUNT_RESET   = 7'h00;
  localparam logic [SETUP_BITS-1:0] SETUP_DEFAULT = 64'h0000_0000_0000_0000;
  localparam logic [SETUP_BITS-1:0] SETUP_RESET   = 64'h0000_0000_0000_0000;

  // serial pins that arrive together on the serial clock
  typedef struct packed {
    logic chain_enable_n;
    logic data;
  } serial_link_t;

  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_LOAD  = 2'b01,
    ST_DONE  = 2'b11
  } load_state_t;

endpackage

// ==== rtl/serial_setup_chain_loader.sv ====
// serial setup chain loader: shift-in setup, completion chaining, data pass-through
`timescale 1ns/1ps
module serial_setup_chain_loader
(
  input  wire logic                                   clock,
  input  wire logic                                   arst_n,
  input  wire logic                                   serial_clock,
  input  wire setup_loader_pkg::serial_link_t         config_link_in,
  input  wire logic                                   master_reset_in,
  input  wire logic                                   serial_mode_select,
  output logic                                        config_done_out,
  output logic                                        serial_out,
  output logic                                        queue_ops_ready,
  output logic [setup_loader_pkg::SETUP_BITS-1:0]     setup_word
);
  import setup_loader_pkg::*;

  // ==========================================================================
  // link domain: restart request crossing in
  // ==========================================================================
  logic                  restart_tgl_q;
  logic                  rst_s1_q;
  logic                  rst_s2_q;
  logic                  ack_tgl_q;
  logic                  restart;

  always_ff @(posedge serial_clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= restart_tgl_q;
      rst_s2_q <= rst_s1_q;
    end
  end

  assign restart = rst_s2_q ^ ack_tgl_q;

  always_ff @(posedge serial_clock or negedge arst_n)
  begin
    if (!arst_n)
      ack_tgl_q <= 1'b0;
    else
      ack_tgl_q <= rst_s2_q;
  end

  // ==========================================================================
  // link domain: setup shift register and bit counter
  // ==========================================================================
  logic [SETUP_BITS-1:0] shift_q;
  logic [COUNT_W-1:0]    count_q;
  logic                  done_link_q;
  logic                  shift_en;

  // capture only on enabled edges of a device not yet loaded
  assign shift_en = !config_link_in.chain_enable_n && !done_link_q && !restart;

  always_ff @(posedge serial_clock or negedge arst_n)
  begin
    if (!arst_n)
      shift_q <= SETUP_RESET;
    else if (shift_en)
      shift_q <= {config_link_in.data, shift_q[SETUP_BITS-1:1]};
  end

  always_ff @(posedge serial_clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      count_q     <= COUNT_RESET;
      done_link_q <= 1'b0;
    end
    else if (restart)
    begin
      count_q     <= COUNT_RESET;
      done_link_q <= 1'b0;
    end
    else if (shift_en)
    begin
      count_q <= count_q + 7'h01;
      if (count_q == COUNT_LAST)
        done_link_q <= 1'b1;
    end
  end

  // pass-through once loaded; one serial clock of latency per device
  always_ff @(posedge serial_clock or negedge arst_n)
  begin
    if (!arst_n)
      serial_out <= 1'b0;
    else if (done_link_q && !restart)
      serial_out <= config_link_in.data;
    else
      serial_out <= 1'b0;
  end

  // ==========================================================================
  // system domain: synchronisers
  // ==========================================================================
  logic mr_s1_q;
  logic mr_s2_q;
  logic mode_s1_q;
  logic mode_s2_q;
  logic en_s1_q;
  logic en_s2_q;
  logic done_s1_q;
  logic done_s2_q;
  logic ack_s1_q;
  logic ack_s2_q;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mr_s1_q   <= 1'b1;
      mr_s2_q   <= 1'b1;
      mode_s1_q <= 1'b0;
      mode_s2_q <= 1'b0;
      en_s1_q   <= 1'b1;
      en_s2_q   <= 1'b1;
      done_s1_q <= 1'b0;
      done_s2_q <= 1'b0;
      ack_s1_q  <= 1'b0;
      ack_s2_q  <= 1'b0;
    end
    else
    begin
      mr_s1_q   <= master_reset_in;
      mr_s2_q   <= mr_s1_q;
      mode_s1_q <= serial_mode_select;
      mode_s2_q <= mode_s1_q;
      en_s1_q   <= config_link_in.chain_enable_n;
      en_s2_q   <= en_s1_q;
      done_s1_q <= done_link_q;
      done_s2_q <= done_s1_q;
      ack_s1_q  <= ack_tgl_q;
      ack_s2_q  <= ack_s1_q;
    end
  end

  // ==========================================================================
  // system domain: load sequence
  // ==========================================================================
  load_state_t state_q;
  logic        serial_mode_q;
  logic        load_finished;

  // serial load counts as finished only after the link has seen the restart
  assign load_finished = !serial_mode_q || ((ack_s2_q == restart_tgl_q) && done_s2_q);

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q       <= ST_RESET;
      serial_mode_q <= 1'b0;
      restart_tgl_q <= 1'b0;
    end
    else if (mr_s2_q)
      state_q <= ST_RESET;
    else
    begin
      case (state_q)
        ST_RESET:
        begin
          serial_mode_q <= mode_s2_q;
          restart_tgl_q <= !restart_tgl_q;
          state_q       <= ST_LOAD;
        end
        ST_LOAD:
        begin
          if (load_finished)
            state_q <= ST_DONE;
        end
        ST_DONE:
          state_q <= ST_DONE;
        default:
          state_q <= ST_RESET;
      endcase
    end
  end

  // setup word is static once the link reports done, so sampling it here is safe
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      setup_word <= SETUP_RESET;
    else if (state_q == ST_LOAD && load_finished)
      setup_word <= serial_mode_q ? shift_q : SETUP_DEFAULT;
  end

  // ==========================================================================
  // system domain: completion output and operation gate
  // ==========================================================================
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      config_done_out <= 1'b1;
      queue_ops_ready <= 1'b0;
    end
    else if (state_q == ST_DONE && !mr_s2_q)
    begin
      config_done_out <= en_s2_q;
      queue_ops_ready <= !en_s2_q;
    end
    else
    begin
      config_done_out <= 1'b1;
      queue_ops_ready <= 1'b0;
    end
  end

endmodule

// ==== tb/loader_monitor.sv ====
// port checker for the serial setup chain loader
`timescale 1ns/1ps
module loader_monitor
(
  input wire logic                         clock,
  input wire logic                         arst_n,
  input wire logic                         serial_clock,
  input wire setup_loader_pkg::serial_link_t config_link_in,
  input wire logic                         master_reset_in,
  input wire logic                         serial_mode_select,
  input wire logic                         config_done_out,
  input wire logic                         serial_out,
  input wire logic                         queue_ops_ready,
  input wire logic [63:0]                  setup_word
);
  import setup_loader_pkg::*;
  logic [6:0] bits_q;
  // ==========
  // taken bits, saturating at a full setup word
  always_ff @(posedge serial_clock or negedge arst_n or posedge master_reset_in)
    if (!arst_n || master_reset_in)
      bits_q <= 7'h00;
    else if (!config_link_in.chain_enable_n && bits_q != 7'h40)
      bits_q <= bits_q + 7'h01;
  // ==========
  // checks
  ready_done_a: assert property (@(posedge clock) disable iff (!arst_n)
    queue_ops_ready |-> !config_done_out) else $error("ready early");
  mreset_idle_a: assert property (@(posedge clock) disable iff (!arst_n)
    master_reset_in [*5] |-> config_done_out && !queue_ops_ready) else $error("reset");
  follow_high_a: assert property (@(posedge clock) disable iff (!arst_n)
    !config_done_out && config_link_in.chain_enable_n |-> ##[1:5] config_done_out)
    else $error("stuck low");
  chain_wait_a: assert property (@(posedge clock) disable iff (!arst_n)
    config_link_in.chain_enable_n [*5] |-> config_done_out) else $error("low early");
  default_done_a: assert property (@(posedge clock) disable iff (!arst_n)
    $fell(master_reset_in) && !serial_mode_select && !config_link_in.chain_enable_n
    |-> ##[3:10] !config_done_out) else $error("no default");
  setup_hold_a:
    assert property (@(posedge clock) disable iff (!arst_n || master_reset_in)
    !config_done_out |=> $stable(setup_word)) else $error("setup moved");
  bit_count_a:
    assert property (@(posedge clock) disable iff (!arst_n || master_reset_in)
    !config_done_out && serial_mode_select |-> bits_q == 7'h40) else $error("count");
  pass_thru_a:
    assert property (@(posedge serial_clock) disable iff (!arst_n || master_reset_in)
    !config_done_out |=> serial_out == $past(config_link_in.data)) else $error("pass");
endmodule
bind serial_setup_chain_loader loader_monitor mon (.clock, .arst_n, .serial_clock,
  .config_link_in, .master_reset_in, .serial_mode_select, .config_done_out,
  .serial_out, .queue_ops_ready, .setup_word);

// ==== tb/setup_host_model.sv ====
// host model: makes the link clock and shifts setup frames
`timescale 1ns/1ps
module setup_host_model
(
  output logic                           serial_clock,
  output setup_loader_pkg::serial_link_t config_link_in
);
  import setup_loader_pkg::*;
  initial
  begin
    serial_clock = 1'h0;
    config_link_in = '{chain_enable_n: 1'h0, data: 1'h0};
  end
  // bit k on edge k; skip bits hold enable high
  task automatic shift(input logic [71:0] bits, input logic [71:0] skip);
    // idle edges with enable high let a pending restart reach the link first
    config_link_in.chain_enable_n = 1'h1;
    repeat (4)
    begin
      #62.5 serial_clock = 1'h1;
      #62.5 serial_clock = 1'h0;
    end
    for (int k = 0; k < 72; k++)
    begin
      config_link_in.chain_enable_n = skip[k];
      config_link_in.data = bits[k];
      #62.5 serial_clock = 1'h1;
      #62.5 serial_clock = 1'h0;
    end
    config_link_in = '{chain_enable_n: 1'h1, data: ~bits[71]};
  endtask
endmodule

// ==== tb/tb_top.sv ====
// self-checking bench for the serial setup chain loader
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; \
  $display("ERROR %0t %h %h", $time, a, e); end end
module tb_top;
  import setup_loader_pkg::*;
  logic         clock;
  logic         arst_n;
  logic         master_reset_in;
  logic         serial_mode_select;
  logic         serial_clock;
  serial_link_t config_link_in;
  logic         config_done_out;
  logic         serial_out;
  logic         queue_ops_ready;
  logic [63:0]  setup_word;
  logic [65:0]  exp_q[$];
  logic [65:0]  exp_note;
  logic         write_queue_select_enable;
  logic [71:0]  bits;
  int           n_mismatch = 0;
  int           n_compared = 0;
  int           seed = 32'h9FB6;
  initial
  begin
    clock = 1'h0;
    forever #12.5 clock = ~clock;
  end
  serial_setup_chain_loader dut (.clock, .arst_n, .serial_clock, .config_link_in,
    .master_reset_in, .serial_mode_select, .config_done_out, .serial_out,
    .queue_ops_ready, .setup_word);
  setup_host_model host (.serial_clock, .config_link_in);
  // ==========
  // take the oldest note each time completion moves
  always @(config_done_out)
    if (arst_n === 1'h1)
    begin
      #1;
      exp_note = exp_q.pop_front();
      `CHK({config_done_out, queue_ops_ready, setup_word}, exp_note)
    end
  // queue selects only after completion is low; the block must then be ready
  always @(negedge clock)
  begin
    write_queue_select_enable = !config_done_out && (($random(seed) & 1) != 0);
    if (write_queue_select_enable === 1'h1)
      `CHK(queue_ops_ready, 1'h1)
  end
  task automatic finish_test();
    n_mismatch += exp_q.size();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #100000;
    n_mismatch++;
    finish_test();
  end
  // ==========
  // default setup, then a serial load with an enable gap and pass-through
  initial
  begin
    arst_n = 1'h0;
    master_reset_in = 1'h1;
    serial_mode_select = 1'h0;
    repeat (8) @(negedge clock);
    arst_n = 1'h1;
    exp_q.push_back({1'h0, 1'h1, 64'h0});
    repeat (4) @(negedge clock);
    master_reset_in = 1'h0;
    repeat (20) @(negedge clock);
    $display("default setup test done");
    exp_q.push_back({1'h1, 1'h0, 64'h0});
    master_reset_in = 1'h1;
    serial_mode_select = 1'h1;
    repeat (10) @(negedge clock);
    master_reset_in = 1'h0;
    bits = {8'($random(seed)), $random(seed), $random(seed)};
    exp_q.push_back({1'h0, 1'h1, bits[65:34], bits[31:0]});
    exp_q.push_back({1'h1, 1'h0, bits[65:34], bits[31:0]});
    repeat (10) @(negedge clock);
    #7 host.shift(bits, 72'h3 << 32);
    `CHK(serial_out, bits[71])
    repeat (10) @(negedge clock);
    $display("serial load test done");
    finish_test();
  end
endmodule
